// *** core/efsc_consts.svh ***
// Register offsets, bit positions, reset values and limits of the frame statistics block
`ifndef EFSC_CONSTS_SVH
`define EFSC_CONSTS_SVH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define EFSC_OFS_CTRL 12'h100
`define EFSC_OFS_RX_STAT 12'h104
`define EFSC_OFS_TX_STAT 12'h108
`define EFSC_OFS_RX_MASK 12'h10C
`define EFSC_OFS_TX_MASK 12'h110
`define EFSC_OFS_TX_BYTES_ALL 12'h114
`define EFSC_OFS_TX_FRAMES_ALL 12'h118
`define EFSC_OFS_TX_UNDERFLOW 12'h148
`define EFSC_OFS_TX_CARRIER 12'h160
`define EFSC_OFS_TX_BYTES_GOOD 12'h164
`define EFSC_OFS_TX_FRAMES_GOOD 12'h168
`define EFSC_OFS_RX_FRAMES_ALL 12'h180
`define EFSC_OFS_RX_BYTES_ALL 12'h184
`define EFSC_OFS_RX_BYTES_GOOD 12'h188
`define EFSC_OFS_RX_MULTICAST 12'h190
`define EFSC_OFS_RX_CRC_ERR 12'h194
`define EFSC_OFS_RX_LEN_ERR 12'h1C8
`define EFSC_OFS_RX_OVERFLOW 12'h1D4
`define EFSC_OFS_CSUM_MASK 12'h200
`define EFSC_OFS_CSUM_STAT 12'h208
// ****************************************
// Control bits
// ****************************************
`define EFSC_CTRL_RESET 0
`define EFSC_CTRL_STOP_ROLL 1
`define EFSC_CTRL_CLR_ON_READ 2
`define EFSC_CTRL_FREEZE 3
// ****************************************
// Status and mask bit positions
// ****************************************
`define EFSC_TXB_BYTES_ALL 0
`define EFSC_TXB_FRAMES_ALL 1
`define EFSC_TXB_UNDERFLOW 13
`define EFSC_TXB_CARRIER 19
`define EFSC_TXB_BYTES_GOOD 20
`define EFSC_TXB_FRAMES_GOOD 21
`define EFSC_RXB_FRAMES_ALL 0
`define EFSC_RXB_BYTES_ALL 1
`define EFSC_RXB_BYTES_GOOD 2
`define EFSC_RXB_MULTICAST 4
`define EFSC_RXB_CRC_ERR 5
`define EFSC_RXB_LEN_ERR 18
`define EFSC_RXB_OVERFLOW 21
`define EFSC_TX_BITS 32'h0038_2003
`define EFSC_RX_BITS 32'h0024_0037
`define EFSC_CSUM_BITS 32'h2A42_2A63
// ****************************************
// Reset values and limits
// ****************************************
`define EFSC_RST_WORD 32'h0000_0000
`define EFSC_RST_CTRL 3'h0
`define EFSC_CNT_MAX 32'hFFFF_FFFF
`define EFSC_CNT_ONE 32'h0000_0001
`endif

// *** core/efsc_pkg.sv ***
// Types shared by the frame statistics block
package efsc_pkg;
	typedef enum logic [0:0] {EFSC_BUS_IDLE = 1'b0, EFSC_BUS_READ = 1'b1} efsc_bus_state_t;
	typedef logic [31:0] efsc_word_t;
endpackage

// *** core/efsc_counters.sv ***
// Frame statistics counters with AHB-Lite register access
// Operation
// - Each counter flags an event on reaching half maximum and again on reaching maximum.
// - Transmit mask bits 21,20,19,13,1,0 suppress the six transmit counter interrupts.
// - Receive mask bits 2,1,0 mask good bytes, all bytes, all frames.
// - Transmit all-frame byte counter adds bytes of good and bad frames, not retries.
// - Transmit all-frame counter counts every frame except retried ones.
// - Transmit underflow counter counts frames aborted by data underflow.
// - Transmit carrier counter counts frames aborted by absent or lost carrier.
// - Transmit good-byte counter adds bytes of good frames only.
// - Transmit good-frame counter counts frames sent without error.
// - Receive all-frame counter counts every received frame.
// - Receive all-frame byte counter adds bytes of every received frame.
// - Receive good-byte counter adds bytes of good received frames only.
// - Receive multicast counter counts good multicast frames.
// - Receive CRC counter counts frames with a bad check sequence.
// - Receive length counter counts size mismatches where the length field is valid.
// - Receive overflow counter counts frames lost to receive FIFO overflow.
// - Checksum mask bits 29,27,25,22,17 mask the checksum byte counter interrupts.
// - Checksum mask bits 13,11,9,6,5,1,0 mask the checksum frame counter interrupts.
// - Checksum status flags set on threshold events and clear when read.
// - Transmit status flags sit at the mask positions and clear when read.
// - Freeze stops all frame updates; clear-on-read still clears a read counter.
// - With stop-rollover set a counter holds at its maximum.
// - With clear-on-read set a counter clears after a read of its low byte.
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ns
`include "efsc_consts.svh"
module efsc_counters
	import efsc_pkg::*;
#(
	parameter int BYTE_CNT_WIDTH = 16
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Transmit frame path, sampled on txFrameEnd
	input wire logic txFrameEnd,
	input wire logic txFrameGood,
	input wire logic txRetried,
	input wire logic txUnderflowAbort,
	input wire logic txCarrierAbort,
	input wire logic [BYTE_CNT_WIDTH-1:0] txByteCount,
	// Receive frame path, sampled on rxFrameEnd; rxOverflowDrop counts on its own
	input wire logic rxFrameEnd,
	input wire logic rxFrameGood,
	input wire logic rxMulticast,
	input wire logic rxCrcError,
	input wire logic rxLengthFieldValid,
	input wire logic rxLengthMismatch,
	input wire logic [BYTE_CNT_WIDTH-1:0] rxByteCount,
	input wire logic rxOverflowDrop,
	// Threshold events of the checksum offload counters
	input wire logic [31:0] csumEvent,
	// Interrupt
	output logic intr
);
	// ****************************************
	// Counter table
	// ****************************************
	localparam int NUM_CNT = 13;
	localparam logic [11:0] CNT_OFS [NUM_CNT] = '{`EFSC_OFS_TX_BYTES_ALL, `EFSC_OFS_TX_FRAMES_ALL,
		`EFSC_OFS_TX_UNDERFLOW, `EFSC_OFS_TX_CARRIER, `EFSC_OFS_TX_BYTES_GOOD, `EFSC_OFS_TX_FRAMES_GOOD,
		`EFSC_OFS_RX_FRAMES_ALL, `EFSC_OFS_RX_BYTES_ALL, `EFSC_OFS_RX_BYTES_GOOD, `EFSC_OFS_RX_MULTICAST,
		`EFSC_OFS_RX_CRC_ERR, `EFSC_OFS_RX_LEN_ERR, `EFSC_OFS_RX_OVERFLOW};
	localparam int CNT_BIT [NUM_CNT] = '{`EFSC_TXB_BYTES_ALL, `EFSC_TXB_FRAMES_ALL, `EFSC_TXB_UNDERFLOW,
		`EFSC_TXB_CARRIER, `EFSC_TXB_BYTES_GOOD, `EFSC_TXB_FRAMES_GOOD, `EFSC_RXB_FRAMES_ALL,
		`EFSC_RXB_BYTES_ALL, `EFSC_RXB_BYTES_GOOD, `EFSC_RXB_MULTICAST, `EFSC_RXB_CRC_ERR,
		`EFSC_RXB_LEN_ERR, `EFSC_RXB_OVERFLOW};
	// Which counters belong to the receive group, and which add byte counts
	localparam logic [NUM_CNT-1:0] CNT_RX = 13'h1FC0;
	localparam logic [NUM_CNT-1:0] CNT_BYTES = 13'h0191;

	efsc_bus_state_t state_reg, state_next;
	logic [11:0] rdAddr_reg, wrAddr_reg;
	logic wrPend_reg;
	efsc_word_t hrdata_reg, rdData;
	logic [2:0] ctrl_reg, ctrl_next;
	efsc_word_t txMask_reg, rxMask_reg, csumMask_reg;
	efsc_word_t txStat_reg, rxStat_reg, csumStat_reg;
	efsc_word_t txStat_next, rxStat_next, csumStat_next;
	efsc_word_t txSet, rxSet;
	efsc_word_t cnt_reg [NUM_CNT];
	efsc_word_t incAmt [NUM_CNT];
	efsc_word_t evtBits [NUM_CNT];
	logic [NUM_CNT-1:0] incHit, cntTouch, cntStep;
	logic addrPhase, rdAccept, wrAccept, wrCommit, rdLatch;
	logic ctrlWr, cntReset, stopRoll, clrOnRead, freeze, txCount;
	efsc_word_t txBytes, rxBytes;

	// ****************************************
	// AHB-Lite slave
	// ****************************************
	// Reads take one wait state so that read data comes from a flip-flop
	assign addrPhase = hsel && htrans[1] && hready;
	assign rdAccept = addrPhase && !hwrite;
	assign wrAccept = addrPhase && hwrite;
	assign wrCommit = wrPend_reg && hready;
	assign rdLatch = (state_reg == EFSC_BUS_READ);
	assign state_next = rdAccept ? EFSC_BUS_READ : EFSC_BUS_IDLE;
	assign hreadyout = (state_reg == EFSC_BUS_IDLE);
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;

	// Bus phase tracking; a new write may be taken while the last one commits
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			state_reg <= EFSC_BUS_IDLE;
			rdAddr_reg <= 12'h000;
			wrAddr_reg <= 12'h000;
			wrPend_reg <= 1'b0;
			hrdata_reg <= `EFSC_RST_WORD;
		end
		else
		begin
			state_reg <= state_next;
			rdAddr_reg <= rdAccept ? haddr[11:0] : rdAddr_reg;
			wrAddr_reg <= wrAccept ? haddr[11:0] : wrAddr_reg;
			wrPend_reg <= wrAccept || (wrPend_reg && !wrCommit);
			hrdata_reg <= rdLatch ? rdData : hrdata_reg;
		end
	end

	// Read multiplexer; unmapped offsets read as zero
	always_comb
	begin
		rdData = `EFSC_RST_WORD;
		case (rdAddr_reg)
			`EFSC_OFS_CTRL: rdData = {28'h000_0000, ctrl_reg, 1'b0};
			`EFSC_OFS_RX_STAT: rdData = rxStat_reg;
			`EFSC_OFS_TX_STAT: rdData = txStat_reg;
			`EFSC_OFS_RX_MASK: rdData = rxMask_reg;
			`EFSC_OFS_TX_MASK: rdData = txMask_reg;
			`EFSC_OFS_CSUM_MASK: rdData = csumMask_reg;
			`EFSC_OFS_CSUM_STAT: rdData = csumStat_reg;
			default: rdData = `EFSC_RST_WORD;
		endcase
		for (int k = 0; k < NUM_CNT; k++)
		begin
			if (rdAddr_reg == CNT_OFS[k])
				rdData = cnt_reg[k];
		end
	end

	// ****************************************
	// Control and mask registers
	// ****************************************
	// Counter reset is a self-clearing pulse, so it is never stored
	assign ctrlWr = wrCommit && (wrAddr_reg == `EFSC_OFS_CTRL);
	assign ctrl_next = ctrlWr ? hwdata[`EFSC_CTRL_FREEZE:`EFSC_CTRL_STOP_ROLL] : ctrl_reg;
	assign cntReset = ctrlWr && hwdata[`EFSC_CTRL_RESET];
	assign stopRoll = ctrl_reg[`EFSC_CTRL_STOP_ROLL - 1];
	assign clrOnRead = ctrl_reg[`EFSC_CTRL_CLR_ON_READ - 1];
	assign freeze = ctrl_reg[`EFSC_CTRL_FREEZE - 1];

	// Mask registers keep only their defined bits
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			ctrl_reg <= `EFSC_RST_CTRL;
			txMask_reg <= `EFSC_RST_WORD;
			rxMask_reg <= `EFSC_RST_WORD;
			csumMask_reg <= `EFSC_RST_WORD;
		end
		else
		begin
			ctrl_reg <= ctrl_next;
			if (wrCommit && (wrAddr_reg == `EFSC_OFS_TX_MASK))
				txMask_reg <= hwdata & `EFSC_TX_BITS;
			if (wrCommit && (wrAddr_reg == `EFSC_OFS_RX_MASK))
				rxMask_reg <= hwdata & `EFSC_RX_BITS;
			if (wrCommit && (wrAddr_reg == `EFSC_OFS_CSUM_MASK))
				csumMask_reg <= hwdata & `EFSC_CSUM_BITS;
		end
	end

	// ****************************************
	// Count strobes from the frame path
	// ****************************************
	// Retried attempts are left out of every all-frame and good count
	assign txCount = txFrameEnd && !txRetried;
	assign txBytes = 32'(txByteCount);
	assign rxBytes = 32'(rxByteCount);
	assign incHit[0] = txCount;
	assign incHit[1] = txCount;
	assign incHit[2] = txFrameEnd && txUnderflowAbort;
	assign incHit[3] = txFrameEnd && txCarrierAbort;
	assign incHit[4] = txCount && txFrameGood;
	assign incHit[5] = txCount && txFrameGood;
	assign incHit[6] = rxFrameEnd;
	assign incHit[7] = rxFrameEnd;
	assign incHit[8] = rxFrameEnd && rxFrameGood;
	assign incHit[9] = rxFrameEnd && rxFrameGood && rxMulticast;
	assign incHit[10] = rxFrameEnd && rxCrcError;
	assign incHit[11] = rxFrameEnd && rxLengthFieldValid && rxLengthMismatch;
	assign incHit[12] = rxOverflowDrop;

	// ****************************************
	// Counters
	// ****************************************
	generate
		for (genvar i = 0; i < NUM_CNT; i++)
		begin : gCnt
			logic [32:0] sum;
			efsc_word_t stepVal, cnt_next;
			logic wrHit, rdClr, step, halfEvt, fullEvt;
			// Byte counters add the frame length, the others add one
			assign incAmt[i] = CNT_BYTES[i] ? (CNT_RX[i] ? rxBytes : txBytes) : `EFSC_CNT_ONE;
			assign sum = {1'b0, cnt_reg[i]} + {1'b0, incAmt[i]};
			assign step = incHit[i] && !freeze;
			assign stepVal = (sum[32] && stopRoll) ? `EFSC_CNT_MAX : sum[31:0];
			assign wrHit = wrCommit && (wrAddr_reg == CNT_OFS[i]);
			// Every counter offset is word aligned, so a hit always covers the low byte
			assign rdClr = rdLatch && clrOnRead && (rdAddr_reg == CNT_OFS[i]);
			assign cntTouch[i] = wrHit || rdClr;
			assign cntStep[i] = step;
			// A held counter at maximum raises no further full events
			assign halfEvt = step && !cnt_reg[i][31] && (sum[31] || sum[32]);
			assign fullEvt = step && (cnt_reg[i] != `EFSC_CNT_MAX) && (sum[32] || (sum[31:0] == `EFSC_CNT_MAX));
			assign evtBits[i] = (halfEvt || fullEvt) ? (`EFSC_CNT_ONE << CNT_BIT[i]) : `EFSC_RST_WORD;
			// A frame counted in a clear-on-read cycle is kept; a counter reset or write drops it
			assign cnt_next = cntReset ? `EFSC_RST_WORD :
				wrHit ? hwdata :
				rdClr ? (step ? incAmt[i] : `EFSC_RST_WORD) :
				step ? stepVal : cnt_reg[i];
			always_ff @(posedge mclk)
			begin
				if (!rst_n)
					cnt_reg[i] <= `EFSC_RST_WORD;
				else
					cnt_reg[i] <= cnt_next;
			end
		end
	endgenerate

	// ****************************************
	// Status flags and interrupt
	// ****************************************
	// Gather counter events into the two status words
	always_comb
	begin
		txSet = `EFSC_RST_WORD;
		rxSet = `EFSC_RST_WORD;
		for (int k = 0; k < NUM_CNT; k++)
		begin
			if (CNT_RX[k])
				rxSet = rxSet | evtBits[k];
			else
				txSet = txSet | evtBits[k];
		end
	end

	// Read clears the word, but an event in the same cycle survives
	assign txStat_next = (rdLatch && (rdAddr_reg == `EFSC_OFS_TX_STAT)) ? txSet : (txStat_reg | txSet);
	assign rxStat_next = (rdLatch && (rdAddr_reg == `EFSC_OFS_RX_STAT)) ? rxSet : (rxStat_reg | rxSet);
	assign csumStat_next = ((rdLatch && (rdAddr_reg == `EFSC_OFS_CSUM_STAT)) ? `EFSC_RST_WORD : csumStat_reg)
		| (csumEvent & `EFSC_CSUM_BITS);

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			txStat_reg <= `EFSC_RST_WORD;
			rxStat_reg <= `EFSC_RST_WORD;
			csumStat_reg <= `EFSC_RST_WORD;
		end
		else
		begin
			txStat_reg <= txStat_next & `EFSC_TX_BITS;
			rxStat_reg <= rxStat_next & `EFSC_RX_BITS;
			csumStat_reg <= csumStat_next;
		end
	end

	// Level interrupt built from flip-flops only
	assign intr = |(txStat_reg & ~txMask_reg) || |(rxStat_reg & ~rxMask_reg)
		|| |(csumStat_reg & ~csumMask_reg);

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	property p_half_flag;
		cntStep[6] && !cntTouch[6] && !cntReset && (cnt_reg[6] == 32'h7FFF_FFFF) |=> rxStat_reg[0];
	endproperty
	a_half_flag: assert property (p_half_flag) else $error("half threshold did not set flag");

	property p_tx_mask;
		(txMask_reg == `EFSC_TX_BITS) && (rxStat_reg == 32'h0000_0000) && (csumStat_reg == 32'h0000_0000) |-> !intr;
	endproperty
	a_tx_mask: assert property (p_tx_mask) else $error("masked tx flag raised interrupt");

	property p_rx_mask;
		(rxMask_reg == `EFSC_RX_BITS) && (txStat_reg == 32'h0000_0000) && (csumStat_reg == 32'h0000_0000) |-> !intr;
	endproperty
	a_rx_mask: assert property (p_rx_mask) else $error("masked rx flag raised interrupt");

	property p_tx_bytes;
		cntStep[0] && !cntTouch[0] && !cntReset && !stopRoll |=> cnt_reg[0] == $past(cnt_reg[0]) + $past(incAmt[0]);
	endproperty
	a_tx_bytes: assert property (p_tx_bytes) else $error("tx byte counter sum wrong");

	property p_tx_retry;
		txFrameEnd && txRetried && !cntTouch[1] && !cntTouch[5] && !cntReset |=> $stable(cnt_reg[1]) && $stable(cnt_reg[5]);
	endproperty
	a_tx_retry: assert property (p_tx_retry) else $error("retried frame was counted");

	property p_freeze;
		freeze && !cntTouch[6] && !cntReset |=> $stable(cnt_reg[6]);
	endproperty
	a_freeze: assert property (p_freeze) else $error("counter moved while frozen");

	property p_stop_roll;
		stopRoll && (cnt_reg[6] == `EFSC_CNT_MAX) && !cntTouch[6] && !cntReset |=> cnt_reg[6] == `EFSC_CNT_MAX;
	endproperty
	a_stop_roll: assert property (p_stop_roll) else $error("counter left maximum under stop rollover");

	property p_wrap;
		!stopRoll && cntStep[6] && (cnt_reg[6] == `EFSC_CNT_MAX) && !cntTouch[6] && !cntReset |=> cnt_reg[6] == 32'h0000_0000;
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter did not wrap to zero");

	property p_clr_read;
		rdLatch && clrOnRead && (rdAddr_reg == `EFSC_OFS_RX_CRC_ERR) && !cntStep[10] && !cntReset |=> cnt_reg[10] == 0;
	endproperty
	a_clr_read: assert property (p_clr_read) else $error("counter not cleared by read");

	property p_csum_flag;
		csumEvent[29] |=> csumStat_reg[29] ##1 (csumStat_reg[29] || rdLatch || $past(rdLatch));
	endproperty
	a_csum_flag: assert property (p_csum_flag) else $error("checksum flag not set");

	property p_read_wait;
		rdAccept |=> !hreadyout ##1 (hreadyout && (hrdata == $past(rdData)));
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("read answer timing wrong");

	c_read: cover property (rdAccept ##1 !hreadyout ##1 hreadyout);
	c_write: cover property (wrAccept ##1 wrCommit);
	c_half: cover property (|txSet);
	c_freeze: cover property (freeze && |incHit);
endmodule

// *** dv/efsc_counters_tb.sv ***
// Self-checking testbench of the frame statistics counter block
`timescale 1ns/1ns
`include "efsc_consts.svh"
module efsc_counters_tb;
	import efsc_pkg::*;
	// Clock, reset and bus
	logic mclk, rst_n, hsel, hwrite, hreadyout, hresp, intr;
	logic [31:0] haddr, hwdata, hrdata, csumEvent;
	logic [1:0] htrans;
	logic [2:0] hsize;
	// Frame path strobes
	logic txFrameEnd, txFrameGood, txRetried, txUnderflowAbort, txCarrierAbort;
	logic rxFrameEnd, rxFrameGood, rxMulticast, rxCrcError, rxLengthFieldValid, rxLengthMismatch, rxOverflowDrop;
	logic [15:0] txByteCount, rxByteCount;
	int err_total, n_compared, seed, i;
	efsc_word_t exp[13], rv;
	logic [11:0] ofs[13] = '{`EFSC_OFS_TX_BYTES_ALL, `EFSC_OFS_TX_FRAMES_ALL, `EFSC_OFS_TX_UNDERFLOW,
		`EFSC_OFS_TX_CARRIER, `EFSC_OFS_TX_BYTES_GOOD, `EFSC_OFS_TX_FRAMES_GOOD, `EFSC_OFS_RX_FRAMES_ALL,
		`EFSC_OFS_RX_BYTES_ALL, `EFSC_OFS_RX_BYTES_GOOD, `EFSC_OFS_RX_MULTICAST, `EFSC_OFS_RX_CRC_ERR,
		`EFSC_OFS_RX_LEN_ERR, `EFSC_OFS_RX_OVERFLOW};
	efsc_counters dut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .txFrameEnd(txFrameEnd), .txFrameGood(txFrameGood),
		.txRetried(txRetried), .txUnderflowAbort(txUnderflowAbort), .txCarrierAbort(txCarrierAbort),
		.txByteCount(txByteCount), .rxFrameEnd(rxFrameEnd), .rxFrameGood(rxFrameGood),
		.rxMulticast(rxMulticast), .rxCrcError(rxCrcError), .rxLengthFieldValid(rxLengthFieldValid),
		.rxLengthMismatch(rxLengthMismatch), .rxByteCount(rxByteCount), .rxOverflowDrop(rxOverflowDrop),
		.csumEvent(csumEvent), .intr(intr));
	// ****************************************
	// Clock
	// ****************************************
	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// ****************************************
	// Checking and reporting
	// ****************************************
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
		n_compared++;
		if (g !== e)
		begin
			err_total++;
			$display("Error t=%0t %s got %h exp %h", $time, what, g, e);
		end
	endtask
	// Expected status word after one increment: reaching half way or the maximum sets bit b
	function automatic logic [31:0] thr_exp(input logic [31:0] v, input logic [31:0] a, input int b);
		logic [32:0] s;
		logic hit;
		s = {1'b0, v} + {1'b0, a};
		hit = (v < 32'h8000_0000 && s >= 33'h0_8000_0000) || (v != `EFSC_CNT_MAX && s >= 33'h0_FFFF_FFFF);
		return hit ? (32'h0000_0001 << b) : 32'h0000_0000;
	endfunction
	task automatic summarize();
		$display("Compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Bounded wait on the bus ready, sampled where it stands before the rising edge
	task automatic wait_rdy();
		int k;
		k = 0;
		do
		begin
			@(negedge mclk);
			k++;
		end
		while (hreadyout !== 1'b1 && k < 50);
		if (k >= 50)
		begin
			err_total++;
			$display("Error t=%0t bus wait ran out", $time);
			summarize();
		end
	endtask
	// One single AHB-Lite word transfer; entered just after a rising edge
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {20'h0_0000, a};
		hwrite <= w;
		htrans <= 2'b10;
		wait_rdy();
		@(posedge mclk);
		htrans <= 2'b00;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
		@(posedge mclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 32'h0000_0000, x);
		chk(x, e, "register read");
		chk(hresp, 1'b0, "bus response");
	endtask
	// Transmit frame end with its qualifiers; the model follows the counting rules
	task automatic txf(input logic g, input logic r, input logic u, input logic c, input logic [15:0] n);
		txFrameEnd <= 1'b1;
		txFrameGood <= g;
		txRetried <= r;
		txUnderflowAbort <= u;
		txCarrierAbort <= c;
		txByteCount <= n;
		@(posedge mclk);
		txFrameEnd <= 1'b0;
		@(posedge mclk);
		if (!r)
		begin
			exp[0] += n;
			exp[1]++;
		end
		if (g && !r)
		begin
			exp[4] += n;
			exp[5]++;
		end
		exp[2] += u;
		exp[3] += c;
	endtask
	// Receive frame end with qualifiers, plus an independent overflow drop
	task automatic rxf(input logic g, input logic m, input logic c, input logic lv, input logic lm,
		input logic o, input logic [15:0] n);
		rxFrameEnd <= 1'b1;
		rxFrameGood <= g;
		rxMulticast <= m;
		rxCrcError <= c;
		rxLengthFieldValid <= lv;
		rxLengthMismatch <= lm;
		rxOverflowDrop <= o;
		rxByteCount <= n;
		@(posedge mclk);
		rxFrameEnd <= 1'b0;
		rxOverflowDrop <= 1'b0;
		@(posedge mclk);
		exp[6]++;
		exp[7] += n;
		exp[8] += g ? n : 16'h0000;
		exp[9] += g & m;
		exp[10] += c;
		exp[11] += lv & lm;
		exp[12] += o;
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		{hsel, hwrite, htrans, haddr, hwdata, csumEvent} = '0;
		hsize = 3'b010;
		{txFrameEnd, txFrameGood, txRetried, txUnderflowAbort, txCarrierAbort, txByteCount} = '0;
		{rxFrameEnd, rxFrameGood, rxMulticast, rxCrcError, rxLengthFieldValid, rxLengthMismatch} = '0;
		{rxOverflowDrop, rxByteCount} = '0;
		err_total = 0;
		n_compared = 0;
		seed = 32'h51e976f9;
		rst_n = 1'b0;
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		// Reset values, unmapped and read-only places
		for (i = 0; i < 13; i++)
			rd(ofs[i], `EFSC_RST_WORD);
		rd(`EFSC_OFS_TX_MASK, `EFSC_RST_WORD);
		rd(`EFSC_OFS_CSUM_STAT, `EFSC_RST_WORD);
		wr(12'h1FC, 32'hFFFF_FFFF);
		rd(12'h1FC, `EFSC_RST_WORD);
		wr(`EFSC_OFS_TX_STAT, 32'hFFFF_FFFF);
		rd(`EFSC_OFS_TX_STAT, `EFSC_RST_WORD);
		$display("Test reset values done");
		// Mask registers hold exactly their documented bits
		wr(`EFSC_OFS_TX_MASK, 32'hFFFF_FFFF);
		rd(`EFSC_OFS_TX_MASK, `EFSC_TX_BITS);
		wr(`EFSC_OFS_RX_MASK, 32'hFFFF_FFFF);
		rd(`EFSC_OFS_RX_MASK, `EFSC_RX_BITS);
		wr(`EFSC_OFS_CSUM_MASK, 32'hFFFF_FFFF);
		rd(`EFSC_OFS_CSUM_MASK, `EFSC_CSUM_BITS);
		for (i = 0; i < 13; i++)
		begin
			exp[i] = $random(seed) & 32'h3FFF_FFFF;
			wr(ofs[i], exp[i]);
		end
		for (i = 0; i < 13; i++)
			rd(ofs[i], exp[i]);
		$display("Test mask and counter access done");
		// Random frames mixed with corner frames; checksum interrupts masked for now
		for (i = 0; i < 40; i++)
		begin
			rv = $random(seed);
			txf(rv[0], rv[1], !rv[0] & rv[2], !rv[0] & rv[3], rv[31:16]);
			rxf(rv[4], rv[5], !rv[4] & rv[6], rv[7], rv[8], rv[9], rv[31:16]);
		end
		txf(1'b0, 1'b1, 1'b1, 1'b0, 16'hFFFF);
		rxf(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 16'h0000);
		for (i = 0; i < 13; i++)
			rd(ofs[i], exp[i]);
		$display("Test random frames done");
		// Half and full events, status clearing and masking
		wr(`EFSC_OFS_TX_MASK, 32'h0000_0000);
		wr(`EFSC_OFS_RX_MASK, 32'h0000_0000);
		wr(`EFSC_OFS_CSUM_MASK, 32'h0000_0000);
		wr(`EFSC_OFS_TX_FRAMES_ALL, 32'h7FFF_FFFF);
		wr(`EFSC_OFS_TX_BYTES_ALL, 32'h0000_0000);
		bus(1'b0, `EFSC_OFS_TX_STAT, 32'h0000_0000, rv);
		bus(1'b0, `EFSC_OFS_RX_STAT, 32'h0000_0000, rv);
		chk(intr, 1'b0, "interrupt idle");
		txf(1'b0, 1'b0, 1'b0, 1'b0, 16'h0040);
		chk(intr, 1'b1, "interrupt on half event");
		rd(`EFSC_OFS_TX_STAT, thr_exp(32'h7FFF_FFFF, `EFSC_CNT_ONE, `EFSC_TXB_FRAMES_ALL));
		rd(`EFSC_OFS_TX_STAT, 32'h0000_0000);
		chk(intr, 1'b0, "interrupt after clear");
		wr(`EFSC_OFS_TX_FRAMES_ALL, 32'hFFFF_FFFE);
		txf(1'b0, 1'b0, 1'b0, 1'b0, 16'h0040);
		rd(`EFSC_OFS_TX_STAT, thr_exp(32'hFFFF_FFFE, `EFSC_CNT_ONE, `EFSC_TXB_FRAMES_ALL));
		wr(`EFSC_OFS_TX_MASK, 32'h0000_0002);
		wr(`EFSC_OFS_TX_FRAMES_ALL, 32'h7FFF_FFFF);
		txf(1'b0, 1'b0, 1'b0, 1'b0, 16'h0040);
		chk(intr, 1'b0, "masked interrupt");
		rd(`EFSC_OFS_TX_STAT, thr_exp(32'h7FFF_FFFF, `EFSC_CNT_ONE, `EFSC_TXB_FRAMES_ALL));
		// Receive half event, masked from the interrupt but still flagged
		wr(`EFSC_OFS_RX_MASK, 32'h0000_0001);
		wr(`EFSC_OFS_RX_FRAMES_ALL, 32'h7FFF_FFFF);
		rxf(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0040);
		chk(intr, 1'b0, "masked rx interrupt");
		rd(`EFSC_OFS_RX_STAT, thr_exp(32'h7FFF_FFFF, `EFSC_CNT_ONE, `EFSC_RXB_FRAMES_ALL));
		$display("Test threshold events done");
		// Checksum offload events
		csumEvent <= 32'h2000_0800;
		@(posedge mclk);
		csumEvent <= 32'h0000_0000;
		@(posedge mclk);
		chk(intr, 1'b1, "checksum interrupt");
		rd(`EFSC_OFS_CSUM_STAT, 32'h2000_0800);
		rd(`EFSC_OFS_CSUM_STAT, 32'h0000_0000);
		// Masked checksum events still set their flags but raise no interrupt
		wr(`EFSC_OFS_CSUM_MASK, 32'h2000_0800);
		csumEvent <= 32'h2000_0800;
		@(posedge mclk);
		csumEvent <= 32'h0000_0000;
		@(posedge mclk);
		chk(intr, 1'b0, "masked checksum interrupt");
		rd(`EFSC_OFS_CSUM_STAT, 32'h2000_0800);
		$display("Test checksum events done");
		// Wrap, stop at maximum, freeze and clear on read
		wr(`EFSC_OFS_RX_FRAMES_ALL, `EFSC_CNT_MAX);
		rxf(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0040);
		rd(`EFSC_OFS_RX_FRAMES_ALL, `EFSC_RST_WORD);
		wr(`EFSC_OFS_CTRL, 32'h0000_0002);
		wr(`EFSC_OFS_RX_FRAMES_ALL, `EFSC_CNT_MAX);
		rxf(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0040);
		rd(`EFSC_OFS_RX_FRAMES_ALL, `EFSC_CNT_MAX);
		wr(`EFSC_OFS_CTRL, 32'h0000_000C);
		rd(`EFSC_OFS_CTRL, 32'h0000_000C);
		wr(`EFSC_OFS_RX_FRAMES_ALL, 32'h0000_0005);
		rxf(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0040);
		rd(`EFSC_OFS_RX_FRAMES_ALL, 32'h0000_0005);
		rd(`EFSC_OFS_RX_FRAMES_ALL, `EFSC_RST_WORD);
		wr(`EFSC_OFS_CTRL, 32'h0000_0004);
		rxf(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0040);
		rd(`EFSC_OFS_RX_FRAMES_ALL, `EFSC_CNT_ONE);
		rd(`EFSC_OFS_RX_FRAMES_ALL, `EFSC_RST_WORD);
		rd(`EFSC_OFS_RX_CRC_ERR, exp[10]);
		rd(`EFSC_OFS_RX_CRC_ERR, `EFSC_RST_WORD);
		$display("Test control modes done");
		// Counter reset pulse clears every counter and is never stored
		wr(`EFSC_OFS_CTRL, 32'h0000_0001);
		rd(`EFSC_OFS_CTRL, `EFSC_RST_WORD);
		for (i = 0; i < 13; i++)
			rd(ofs[i], `EFSC_RST_WORD);
		$display("Test counter reset done");
		summarize();
	end
endmodule
